// >>> design/sbbd_decoder.sv
// discard (bit bucket) descriptor decoder with AXI4-Lite registers
// assumes descriptors arrive from logic on CLOCK_IN, one 16-byte entry per beat
//
// Functional notes
// R1: type nibble one marks a discard descriptor
// R2: nonzero low identifier nibble is type error
// R3: destination direction: length counts dropped source bytes
// R4: zero length drops nothing, still valid
// R5: source direction ignores the length entirely
// R6: only destination discard lengths count toward blocks
// R7: reserved bytes 0-7 and 12-14 ignored
// R8: reserved or unsupported type code is an error
// R9: chaining descriptor only last; else abort
`include "sbbd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sbbd_decoder
(
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic [127:0] DESC_DATA_IN,
    input wire logic DESC_VALID_IN,
    input wire logic DESC_LAST_ENTRY_IN,
    input wire logic DESC_LAST_SEG_IN,
    output logic DESC_READY_OUT,
    output logic RES_VALID_OUT,
    output logic [31:0] RES_DROP_OUT,
    output logic RES_TYPE_ERR_OUT,
    output logic RES_ABORT_OUT,
    output logic RES_COUNTED_OUT,
    output logic [31:0] LOGICAL_BLOCK_BYTES_OUT,
    output logic IRQ_OUT
);
    // ************************************************************
    // decode of the incoming entry
    // ************************************************************
    sbbd_pkg::sbbd_state_t s; // registered state
    sbbd_pkg::sbbd_state_t next_s; // next state
    logic take; // entry accepted this edge
    logic [3:0] typ; // descriptor type nibble
    logic [3:0] zr; // identifier low nibble
    logic [31:0] len; // length field, bytes 8..11
    logic clr_now; // counter clear written this edge
    logic wr_go; // register write performed this edge
    // bytes 0-7 and 12-14 are never looked at [R7]
    assign take = DESC_VALID_IN && s.dready;
    assign typ = DESC_DATA_IN[`SBBD_TYPE_HI:`SBBD_TYPE_LO];
    assign zr = DESC_DATA_IN[`SBBD_ZERO_HI:`SBBD_ZERO_LO];
    assign len = DESC_DATA_IN[`SBBD_LEN_HI:`SBBD_LEN_LO];
    assign wr_go = s.aw_have && s.w_have && !s.bvalid;
    assign clr_now = wr_go && (s.aw_addr == `SBBD_CTRL_OFS)
        && s.w_strb[0] && s.w_data[`SBBD_CTRL_CLR_BIT];

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb
    begin
        logic [2:0] ev; // events raised this cycle
        logic [2:0] rclr; // status bits cleared by a read
        logic [31:0] tmp; // merged write value
        ev = 3'h0;
        rclr = 3'h0;
        tmp = 32'h0;
        next_s = s;
        next_s.res_valid = 1'b0;
        next_s.dready = 1'b1;
        // descriptor classification, one entry per cycle
        if (take)
        begin
            next_s.res_valid = 1'b1;
            next_s.res_drop = 32'h0;
            next_s.res_terr = 1'b0;
            next_s.res_abort = 1'b0;
            next_s.res_lb = 1'b0;
            unique case (typ)
                sbbd_pkg::SBBD_BUCKET:
                begin
                    if (zr != 4'h0)
                    begin
                        // low nibble must be zero [R2]
                        next_s.res_terr = 1'b1;
                    end
                    else if (s.dest_dir)
                    begin
                        // drop length bytes, zero drops none [R1] [R3] [R4]
                        next_s.res_drop = len;
                        next_s.res_lb = 1'b1;
                    end
                    // source direction: length disregarded [R5]
                end
                sbbd_pkg::SBBD_DATA:
                begin
                    // data blocks pass untouched, handled downstream
                end
                sbbd_pkg::SBBD_SEG, sbbd_pkg::SBBD_LASTSEG:
                begin
                    // chaining only as final entry of a non-last segment [R9]
                    if (!DESC_LAST_ENTRY_IN || DESC_LAST_SEG_IN)
                    begin
                        next_s.res_abort = 1'b1;
                    end
                end
                default:
                begin
                    // reserved and vendor codes unsupported [R8]
                    next_s.res_terr = 1'b1;
                end
            endcase
            ev[`SBBD_EV_TERR_BIT] = next_s.res_terr;
            ev[`SBBD_EV_ABORT_BIT] = next_s.res_abort;
            ev[`SBBD_EV_DROP_BIT] = next_s.res_lb;
        end
        // write address and data taken in either order
        if (AWVALID_IN && s.awready)
        begin
            next_s.aw_have = 1'b1;
            next_s.aw_addr = AWADDR_IN;
        end
        if (WVALID_IN && s.wready)
        begin
            next_s.w_have = 1'b1;
            next_s.w_data = WDATA_IN;
            next_s.w_strb = WSTRB_IN;
        end
        // counter: clear first, then add, so no discard is lost
        if (clr_now)
        begin
            next_s.total = 32'h0;
        end
        if (take && next_s.res_lb)
        begin
            // destination discards count toward the blocks [R6]
            next_s.total = next_s.total + len;
        end
        // write performed once both halves are held
        if (wr_go)
        begin
            next_s.bvalid = 1'b1;
            next_s.bresp = `SBBD_RESP_OKAY;
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            unique case (s.aw_addr)
                `SBBD_CTRL_OFS:
                begin
                    tmp = merge({31'h0, s.dest_dir}, s.w_data, s.w_strb);
                    next_s.dest_dir = tmp[`SBBD_CTRL_DEST_BIT];
                end
                `SBBD_MASK_OFS:
                begin
                    tmp = merge({29'h0, s.msk}, s.w_data, s.w_strb);
                    next_s.msk = tmp[2:0];
                end
                `SBBD_STATUS_OFS, `SBBD_TOTAL_OFS:
                begin
                    // read-only, write ignored
                end
                default:
                begin
                    next_s.bresp = `SBBD_RESP_SLVERR;
                end
            endcase
        end
        else if (s.bvalid && BREADY_IN)
        begin
            next_s.bvalid = 1'b0;
        end
        // read answers one cycle after the address is taken
        if (ARVALID_IN && s.arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `SBBD_RESP_OKAY;
            unique case (ARADDR_IN)
                `SBBD_CTRL_OFS: next_s.rdata = {31'h0, s.dest_dir};
                `SBBD_STATUS_OFS:
                begin
                    next_s.rdata = {29'h0, s.sts};
                    rclr = s.sts;
                end
                `SBBD_MASK_OFS: next_s.rdata = {29'h0, s.msk};
                `SBBD_TOTAL_OFS: next_s.rdata = s.total;
                default:
                begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = `SBBD_RESP_SLVERR;
                end
            endcase
        end
        else if (s.rvalid && RREADY_IN)
        begin
            next_s.rvalid = 1'b0;
        end
        // sticky status: a new event beats the read clear
        next_s.sts = (s.sts & ~rclr) | ev;
        next_s.awready = !next_s.aw_have && !next_s.bvalid;
        next_s.wready = !next_s.w_have && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
        next_s.irq = |(next_s.sts & next_s.msk);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            s <= '0;
            s.dest_dir <= `SBBD_CTRL_RST;
            s.msk <= `SBBD_MASK_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign AWREADY_OUT = s.awready;
    assign WREADY_OUT = s.wready;
    assign BVALID_OUT = s.bvalid;
    assign BRESP_OUT = s.bresp;
    assign ARREADY_OUT = s.arready;
    assign RVALID_OUT = s.rvalid;
    assign RDATA_OUT = s.rdata;
    assign RRESP_OUT = s.rresp;
    assign DESC_READY_OUT = s.dready;
    assign RES_VALID_OUT = s.res_valid;
    assign RES_DROP_OUT = s.res_drop;
    assign RES_TYPE_ERR_OUT = s.res_terr;
    assign RES_ABORT_OUT = s.res_abort;
    assign RES_COUNTED_OUT = s.res_lb;
    assign LOGICAL_BLOCK_BYTES_OUT = s.total;
    assign IRQ_OUT = s.irq;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    // helper: status read in flight, for the sticky check
    logic rclr_seen;
    assign rclr_seen = ARVALID_IN && s.arready && ARADDR_IN == `SBBD_STATUS_OFS;

    sequence bucket_ok;
        take && typ == 4'h1 && zr == 4'h0;
    endsequence

    a_bucket_drop: assert property (bucket_ok and s.dest_dir |=> // [R3]
        RES_VALID_OUT && RES_DROP_OUT == $past(len) && !RES_TYPE_ERR_OUT)
        else $error("discard length not passed on");
    a_zero_len: assert property (bucket_ok and len == 32'h0 |=> // [R4]
        RES_VALID_OUT && RES_DROP_OUT == 32'h0 && !RES_TYPE_ERR_OUT)
        else $error("zero length discard mishandled");
    a_source_ignore: assert property (take && !s.dest_dir |=> // [R5]
        RES_DROP_OUT == 32'h0 && !RES_COUNTED_OUT)
        else $error("source direction length used");
    a_zero_nibble: assert property (take && typ == 4'h1 && zr != 4'h0 |=> // [R2]
        RES_TYPE_ERR_OUT && !RES_COUNTED_OUT)
        else $error("nonzero low nibble not flagged");
    a_reserved_type: assert property (take && typ > 4'h3 |=> // [R8]
        RES_TYPE_ERR_OUT ##1 s.sts[`SBBD_EV_TERR_BIT] || $past(rclr_seen))
        else $error("reserved type not flagged");
    a_chain_place: assert property (take && (typ == 4'h2 || typ == 4'h3) // [R9]
        && (!DESC_LAST_ENTRY_IN || DESC_LAST_SEG_IN) |=> RES_ABORT_OUT)
        else $error("misplaced chaining not aborted");
    a_block_count: assert property (bucket_ok and s.dest_dir && !clr_now |=> // [R6]
        LOGICAL_BLOCK_BYTES_OUT == $past(s.total) + $past(len))
        else $error("block byte count not advanced");
    a_bucket_type: assert property (RES_VALID_OUT && RES_COUNTED_OUT |-> // [R1]
        $past(typ) == 4'h1 && $past(take))
        else $error("counted entry was not a discard");
    a_irq_level: assert property (RES_VALID_OUT && RES_TYPE_ERR_OUT
        && s.msk[`SBBD_EV_TERR_BIT] |-> IRQ_OUT)
        else $error("masked-in event without interrupt");
    a_write_resp: assert property ($rose(BVALID_OUT) |->
        $past(s.aw_have) && $past(s.w_have))
        else $error("write answered before both halves");
endmodule : sbbd_decoder
`default_nettype wire

// >>> design/sbbd_regs.svh
// register offsets, field positions and reset values of the discard decoder
// assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register
`ifndef SBBD_REGS_SVH
`define SBBD_REGS_SVH
`define SBBD_CTRL_OFS 8'h00
`define SBBD_STATUS_OFS 8'h04
`define SBBD_MASK_OFS 8'h08
`define SBBD_TOTAL_OFS 8'h0C
`define SBBD_CTRL_DEST_BIT 0
`define SBBD_CTRL_CLR_BIT 1
`define SBBD_EV_TERR_BIT 0
`define SBBD_EV_ABORT_BIT 1
`define SBBD_EV_DROP_BIT 2
`define SBBD_TYPE_HI 127
`define SBBD_TYPE_LO 124
`define SBBD_ZERO_HI 123
`define SBBD_ZERO_LO 120
`define SBBD_LEN_HI 95
`define SBBD_LEN_LO 64
`define SBBD_RESP_OKAY 2'h0
`define SBBD_RESP_SLVERR 2'h2
`define SBBD_CTRL_RST 1'h0
`define SBBD_MASK_RST 3'h0
`endif

// >>> design/sbbd_pkg.sv
// types shared by the discard decoder
// assumes the offsets and fields come from sbbd_regs.svh
package sbbd_pkg;
    // descriptor type codes in the identifier's upper nibble
    typedef enum logic [3:0]
    {
        SBBD_DATA = 4'h0,
        SBBD_BUCKET = 4'h1,
        SBBD_SEG = 4'h2,
        SBBD_LASTSEG = 4'h3
    } sbbd_dtype_t;
    // whole state of the decoder, registered once
    typedef struct packed
    {
        logic dest_dir;
        logic [2:0] sts;
        logic [2:0] msk;
        logic [31:0] total;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
        logic dready;
        logic res_valid;
        logic [31:0] res_drop;
        logic res_terr;
        logic res_abort;
        logic res_lb;
    } sbbd_state_t;
endpackage : sbbd_pkg

// >>> dv/sbbd_host_mem.sv
// host memory model: serves one descriptor list, one entry a beat
// assumes the decoder samples ready on the rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none
module sbbd_host_mem
(
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [3:0] count_in,
    input wire logic ready_in,
    output logic [127:0] data_out,
    output logic valid_out,
    output logic last_entry_out,
    output logic last_seg_out,
    output logic busy_out
);
    logic [129:0] mem [0:15]; // {last seg, last entry, entry}
    logic [3:0] idx; // entry on offer
    initial
    begin
        data_out = '0;
        valid_out = 1'b0;
        last_entry_out = 1'b0;
        last_seg_out = 1'b0;
        busy_out = 1'b0;
        idx = 4'h0;
    end
    // entries and list flags held until taken
    always @(posedge clk_in)
    begin
        if (!busy_out && go_in)
        begin
            busy_out <= 1'b1;
            idx <= 4'h0;
            valid_out <= 1'b1;
            {last_seg_out, last_entry_out, data_out} <= mem[0];
        end
        else if (valid_out && ready_in)
        begin
            if (idx + 4'h1 == count_in)
            begin
                // released data lines flip and list flags clear so stale data cannot pass
                busy_out <= 1'b0;
                valid_out <= 1'b0;
                data_out <= ~data_out;
                {last_seg_out, last_entry_out} <= 2'h0;
            end
            else
            begin
                idx <= idx + 4'h1;
                {last_seg_out, last_entry_out, data_out} <= mem[idx + 4'h1];
            end
        end
    end
endmodule : sbbd_host_mem
`default_nettype wire

// >>> dv/sbbd_decoder_tb.sv
// self-checking bench of the discard decoder
// assumes sbbd_regs.svh on the include path
`include "sbbd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sbbd_decoder_tb;
    logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, go;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb, nent;
    wire logic awready, wready, bvalid, arready, rvalid, dvalid, dle, dls;
    wire logic dready, busy, rv, terr, abort, counted, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, drop, total;
    wire logic [127:0] ddata;
    logic [34:0] got [$], exps [$], cares [$]; // {drop, terr, abort, counted}
    int bad_count, comparisons, cyc;
    sbbd_decoder sbbd_decoder_inst (.CLOCK_IN(clk), .ARST_N_IN(arst_n),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
        .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
        .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
        .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
        .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
        .DESC_DATA_IN(ddata), .DESC_VALID_IN(dvalid), .DESC_LAST_ENTRY_IN(dle),
        .DESC_LAST_SEG_IN(dls), .DESC_READY_OUT(dready), .RES_VALID_OUT(rv),
        .RES_DROP_OUT(drop), .RES_TYPE_ERR_OUT(terr), .RES_ABORT_OUT(abort),
        .RES_COUNTED_OUT(counted), .LOGICAL_BLOCK_BYTES_OUT(total), .IRQ_OUT(irq));
    sbbd_host_mem sbbd_host_mem_inst (.clk_in(clk), .go_in(go), .count_in(nent),
        .ready_in(dready), .data_out(ddata), .valid_out(dvalid), .last_entry_out(dle),
        .last_seg_out(dls), .busy_out(busy));
    // free running 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // results are taken in their one pulse cycle
    always @(posedge clk)
    begin
        if (rv)
            got.push_back({drop, terr, abort, counted});
    end
    // hang guard, far above the roughly 135 cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    // write: both halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
        input logic [1:0] er);
        logic aw_d;
        logic w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_d && w_d))
        begin
            @(posedge clk);
            if (!aw_d && awready)
            begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_d && wready)
            begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        check("write resp", {33'h0, bresp}, {33'h0, er});
        // one idle edge so a following call never re-drives in this step
        @(posedge clk);
    endtask : wr
    // read and compare data with response
    task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        check("register", {1'b0, rresp, rdata}, {1'b0, er, ed});
        // one idle edge so a following call never re-drives in this step
        @(posedge clk);
    endtask : rchk
    // type code sits in the top nibble of byte 15
    function automatic logic [129:0] ent(input logic [3:0] t, input logic [3:0] z,
        input logic [31:0] n, input logic le, input logic ls, input logic [7:0] r);
        return {ls, le, t, z, {3{r}}, n, {8{r}}};
    endfunction : ent
    task automatic add(input logic [129:0] e, input logic [34:0] x, input logic [34:0] c);
        sbbd_host_mem_inst.mem[nent] = e;
        nent = nent + 4'h1;
        exps.push_back(x);
        cares.push_back(c);
    endtask : add
    // stream the list, then compare every result
    task automatic run;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy);
        repeat (2) @(posedge clk);
        check("count", 35'(got.size()), 35'(nent));
        foreach (exps[i])
            check("result", got[i] & cares[i], exps[i]);
        got.delete();
        exps.delete();
        cares.delete();
        nent = 4'h0;
    endtask : run
    localparam logic [34:0] ALL = 35'h7FFFFFFFF; // whole result compared
    localparam logic [34:0] FL = 35'h7; // flags only, drop left open
    initial
    begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, go} = 7'h0;
        {awaddr, araddr, wdata, wstrb, nent} = '0;
        {bad_count, comparisons, cyc} = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("ready", 35'(dready), 35'h1);
        for (int a = 0; a < 20; a += 4)
            rchk(8'(a), 32'h0, a == 16 ? `SBBD_RESP_SLVERR : `SBBD_RESP_OKAY);
        // destination direction, every event unmasked
        wr(`SBBD_CTRL_OFS, 32'h1, 4'hF, `SBBD_RESP_OKAY);
        wr(`SBBD_MASK_OFS, 32'h7, 4'hF, `SBBD_RESP_OKAY);
        add(ent(4'h1, 4'h0, 32'h100, 0, 0, 8'h0), {32'h100, 3'h1}, ALL); // drop
        add(ent(4'h1, 4'h0, 32'h0, 0, 0, 8'h0), {32'h0, 3'h1}, ALL); // zero
        add(ent(4'h1, 4'h5, 32'h40, 0, 0, 8'h0), {32'h0, 3'h4}, FL); // low nibble
        add(ent(4'h4, 4'h0, 32'h40, 0, 0, 8'h0), {32'h0, 3'h4}, FL); // reserved
        add(ent(4'hF, 4'h0, 32'h40, 0, 0, 8'h0), {32'h0, 3'h4}, FL); // vendor
        add(ent(4'h1, 4'h0, 32'h20, 0, 0, 8'hA5), {32'h20, 3'h1}, ALL); // junk
        add(ent(4'h2, 4'h0, 32'h10, 0, 0, 8'h0), {32'h0, 3'h2}, FL); // mid chain
        add(ent(4'h3, 4'h0, 32'h10, 1, 0, 8'h0), {32'h0, 3'h0}, FL); // last ok
        add(ent(4'h0, 4'h0, 32'h30, 0, 0, 8'h0), {32'h0, 3'h0}, FL); // data block
        run();
        rchk(`SBBD_TOTAL_OFS, 32'h120, `SBBD_RESP_OKAY); // block total
        check("irq", 35'(irq), 35'h1);
        rchk(`SBBD_STATUS_OFS, 32'h7, `SBBD_RESP_OKAY);
        rchk(`SBBD_STATUS_OFS, 32'h0, `SBBD_RESP_OKAY);
        check("irq", 35'(irq), 35'h0);
        // source direction: length ignored, not counted
        wr(`SBBD_CTRL_OFS, 32'h0, 4'hF, `SBBD_RESP_OKAY);
        wr(`SBBD_MASK_OFS, 32'h3, 4'hF, `SBBD_RESP_OKAY);
        add(ent(4'h1, 4'h0, 32'h55, 0, 0, 8'h0), {32'h0, 3'h0}, ALL); // source
        add(ent(4'h3, 4'h0, 32'h10, 1, 1, 8'h0), {32'h0, 3'h2}, FL); // in last seg
        run();
        rchk(`SBBD_TOTAL_OFS, 32'h120, `SBBD_RESP_OKAY); // unchanged
        check("irq", 35'(irq), 35'h1);
        rchk(`SBBD_STATUS_OFS, 32'h2, `SBBD_RESP_OKAY);
        // masked event, then total cleared by control
        wr(`SBBD_MASK_OFS, 32'h0, 4'hF, `SBBD_RESP_OKAY);
        wr(`SBBD_CTRL_OFS, 32'h1, 4'hF, `SBBD_RESP_OKAY);
        add(ent(4'h1, 4'h0, 32'h8, 0, 0, 8'h0), {32'h8, 3'h1}, ALL); // drop
        run();
        check("irq", 35'(irq), 35'h0);
        rchk(`SBBD_TOTAL_OFS, 32'h128, `SBBD_RESP_OKAY); // sum
        rchk(`SBBD_STATUS_OFS, 32'h4, `SBBD_RESP_OKAY);
        wr(`SBBD_CTRL_OFS, 32'h3, 4'hF, `SBBD_RESP_OKAY);
        rchk(`SBBD_TOTAL_OFS, 32'h0, `SBBD_RESP_OKAY);
        rchk(`SBBD_CTRL_OFS, 32'h1, `SBBD_RESP_OKAY);
        // lane 0 strobed off: direction and clear both untouched
        wr(`SBBD_CTRL_OFS, 32'h2, 4'hE, `SBBD_RESP_OKAY);
        rchk(`SBBD_CTRL_OFS, 32'h1, `SBBD_RESP_OKAY);
        // read-only total ignores writes, unmapped word refused
        wr(`SBBD_TOTAL_OFS, 32'h55, 4'hF, `SBBD_RESP_OKAY);
        rchk(`SBBD_TOTAL_OFS, 32'h0, `SBBD_RESP_OKAY);
        wr(8'h10, 32'h0, 4'hF, `SBBD_RESP_SLVERR);
        tally_and_finish();
    end
endmodule : sbbd_decoder_tb
`default_nettype wire
